// File: hw/rmh_host_port.sv
`timescale 1ns/10ps
module rmh_host_port (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        host_port_timing_strap_i,
  input  wire logic        host_access_i,
  input  wire logic        host_rw_i,
  input  wire logic [6:0]  host_reg_select_i,
  input  wire logic [15:0] host_data_bus_i,
  output logic      [15:0] host_data_bus_o,
  output logic             host_data_bus_oe_o,
  output logic             host_ack_o,
  input  wire logic        init_mode_i,
  input  wire logic [31:0] status_one_i,
  input  wire logic [31:0] status_two_i,
  input  wire logic [15:0] protocol_state_i,
  input  wire logic [31:0] mac_info_value_i,
  output logic      [15:0] command_one_o,
  output logic             command_one_stb_o,
  output logic      [15:0] command_two_o,
  output logic             command_two_stb_o,
  output logic             access_refused_o,
  output logic             host_sync_mode_o,
  output logic      [31:0] int_mask_one_o,
  output logic      [31:0] int_mask_two_o,
  output logic      [15:0] short_individual_addr_o,
  output logic      [47:0] long_individual_addr_o,
  output logic      [15:0] short_group_addr_o,
  output logic      [47:0] long_group_addr_o,
  output logic      [15:0] mode_one_o
);

  // ****************************************************************
  // pin synchronisation and strap capture
  // ****************************************************************
  logic [rmh_pkg::SYNC_W-1:0]                         pins_sync;
  logic                                               strb;
  logic                                               rw;
  logic [6:0]                                         sel;
  logic [15:0]                                        wd;
  logic [rmh_pkg::NUM_WORDS-1:0][rmh_pkg::DATA_W-1:0] words;
  logic [15:0]                                        rf_rdata;

  rmh_sync u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    ({host_port_timing_strap_i, host_access_i, host_rw_i, host_reg_select_i, host_data_bus_i}),
    .sync_o     (pins_sync)
  );

  rmh_pkg::rmh_port_state_t st_r;
  rmh_pkg::rmh_port_state_t st_nxt;
  logic [1:0]               cnt_r;
  logic [1:0]               cnt_nxt;
  logic                     smode_r;
  logic                     smode_nxt;

  always_comb begin
    if (smode_r) begin
      strb = host_access_i;
      rw   = host_rw_i;
      sel  = host_reg_select_i;
      wd   = host_data_bus_i;
    end else begin
      strb = pins_sync[24];
      rw   = pins_sync[23];
      sel  = pins_sync[22:16];
      wd   = pins_sync[15:0];
    end
  end

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic        take;
  logic        take_wr;
  logic        wr_ok;
  logic        refuse;
  logic [15:0] ext;

  always_comb begin
    take    = (st_r == rmh_pkg::PS_IDLE) && strb;
    take_wr = take && (rw != rmh_pkg::HOST_RD);
    refuse  = take_wr && rmh_pkg::is_init_only(sel) && !init_mode_i;
    wr_ok   = take_wr && rmh_pkg::is_word(sel) && !refuse;
    unique case (sel)
      rmh_pkg::A_STATUS_ONE_UPPER: ext = status_one_i[31:16];
      rmh_pkg::A_STATUS_ONE_LOWER: ext = status_one_i[15:0];
      rmh_pkg::A_STATUS_TWO_UPPER: ext = status_two_i[31:16];
      rmh_pkg::A_STATUS_TWO_LOWER: ext = status_two_i[15:0];
      rmh_pkg::A_STM:  ext = protocol_state_i;
      rmh_pkg::A_MIRU: ext = mac_info_value_i[31:16];
      rmh_pkg::A_MIRL: ext = mac_info_value_i[15:0];
      default:         ext = 16'h0000;
    endcase
  end

  rmh_regfile u_regfile (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (wr_ok),
    .wr_idx_i   (rmh_pkg::word_idx(sel)),
    .wr_data_i  (wd),
    .rd_idx_i   (rmh_pkg::word_idx(sel)),
    .rd_data_o  (rf_rdata),
    .words_o    (words)
  );

  // ****************************************************************
  // port sequencer
  // ****************************************************************
  logic        s1_rd_r;
  logic        s1_rd_nxt;
  logic        s1_word_r;
  logic        s1_word_nxt;
  logic [15:0] s1_ext_r;
  logic [15:0] s1_ext_nxt;
  logic [15:0] dout_r;
  logic [15:0] dout_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        ack_r;
  logic        ack_nxt;

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    smode_nxt   = smode_r;
    s1_rd_nxt   = s1_rd_r;
    s1_word_nxt = s1_word_r;
    s1_ext_nxt  = s1_ext_r;
    dout_nxt    = dout_r;
    oe_nxt      = oe_r;
    ack_nxt     = ack_r;
    unique case (st_r)
      rmh_pkg::PS_STRAP: begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == rmh_pkg::STRAP_WAIT) begin
          smode_nxt = pins_sync[25];
          st_nxt    = rmh_pkg::PS_IDLE;
        end
      end
      rmh_pkg::PS_IDLE: begin
        if (take) begin
          s1_rd_nxt   = (rw == rmh_pkg::HOST_RD);
          s1_word_nxt = rmh_pkg::is_word(sel);
          s1_ext_nxt  = ext;
          st_nxt      = rmh_pkg::PS_STAGE;
        end
      end
      rmh_pkg::PS_STAGE: begin
        dout_nxt = s1_word_r ? rf_rdata : s1_ext_r;
        oe_nxt   = s1_rd_r;
        ack_nxt  = 1'b1;
        st_nxt   = rmh_pkg::PS_HOLD;
      end
      rmh_pkg::PS_HOLD: begin
        if (!strb) begin
          oe_nxt  = 1'b0;
          ack_nxt = 1'b0;
          st_nxt  = rmh_pkg::PS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_r      <= rmh_pkg::PS_STRAP;
      cnt_r     <= 2'h0;
      smode_r   <= 1'b0;
      s1_rd_r   <= 1'b0;
      s1_word_r <= 1'b0;
      s1_ext_r  <= 16'h0000;
      dout_r    <= 16'h0000;
      oe_r      <= 1'b0;
      ack_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      smode_r   <= smode_nxt;
      s1_rd_r   <= s1_rd_nxt;
      s1_word_r <= s1_word_nxt;
      s1_ext_r  <= s1_ext_nxt;
      dout_r    <= dout_nxt;
      oe_r      <= oe_nxt;
      ack_r     <= ack_nxt;
    end
  end

  // ****************************************************************
  // command issue and refusal flag
  // ****************************************************************
  logic [15:0] cmd1_r;
  logic [15:0] cmd1_nxt;
  logic [15:0] cmd2_r;
  logic [15:0] cmd2_nxt;
  logic        stb1_r;
  logic        stb1_nxt;
  logic        stb2_r;
  logic        stb2_nxt;
  logic        ref_r;
  logic        ref_nxt;

  always_comb begin
    stb1_nxt = take_wr && (sel == rmh_pkg::A_CMD1);
    stb2_nxt = take_wr && (sel == rmh_pkg::A_CMD2);
    cmd1_nxt = stb1_nxt ? wd : cmd1_r;
    cmd2_nxt = stb2_nxt ? wd : cmd2_r;
    ref_nxt  = refuse;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cmd1_r <= rmh_pkg::CMD_RST;
      cmd2_r <= rmh_pkg::CMD_RST;
      stb1_r <= 1'b0;
      stb2_r <= 1'b0;
      ref_r  <= 1'b0;
    end else begin
      cmd1_r <= cmd1_nxt;
      cmd2_r <= cmd2_nxt;
      stb1_r <= stb1_nxt;
      stb2_r <= stb2_nxt;
      ref_r  <= ref_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign host_data_bus_o         = dout_r;
  assign host_data_bus_oe_o      = oe_r;
  assign host_ack_o              = ack_r;
  assign command_one_o           = cmd1_r;
  assign command_one_stb_o       = stb1_r;
  assign command_two_o           = cmd2_r;
  assign command_two_stb_o       = stb2_r;
  assign access_refused_o        = ref_r;
  assign host_sync_mode_o        = smode_r;
  assign int_mask_one_o          = {words[rmh_pkg::W_MSK1U], words[rmh_pkg::W_MSK1L]};
  assign int_mask_two_o          = {words[rmh_pkg::W_MSK2U], words[rmh_pkg::W_MSK2L]};
  assign short_individual_addr_o = words[rmh_pkg::W_SHORT_INDIVIDUAL_ADDR];
  assign long_individual_addr_o  = {words[rmh_pkg::W_LAIH], words[rmh_pkg::W_LONG_INDIVIDUAL_ADDR_HIGH], words[rmh_pkg::W_LONG_INDIVIDUAL_ADDR_LOW]};
  assign short_group_addr_o      = words[rmh_pkg::W_SHORT_GROUP_ADDR];
  assign long_group_addr_o       = {words[rmh_pkg::W_LAGH], words[rmh_pkg::W_LONG_GROUP_ADDR_HIGH], words[rmh_pkg::W_LONG_GROUP_ADDR_LOW]};
  assign mode_one_o              = words[rmh_pkg::W_MODE];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_CMD_ONE: assert property (take_wr && sel == rmh_pkg::A_CMD1 |=> command_one_stb_o && command_one_o == $past(wd))
    else $error("command one not issued");
  AST_CMD_TWO: assert property (take_wr && sel == rmh_pkg::A_CMD2 |=> command_two_stb_o && !command_one_stb_o)
    else $error("command two not issued");
  AST_REFUSE: assert property (refuse |=> access_refused_o && $stable(mode_one_o) && $stable(long_group_addr_o))
    else $error("init-only write not refused");
  AST_READ_STATUS: assert property (take && rw && sel == rmh_pkg::A_STATUS_ONE_UPPER |-> ##2 host_data_bus_o == $past(status_one_i[31:16], 2))
    else $error("status upper half wrong");
  AST_MASK_WRITE: assert property (wr_ok && sel == 7'h05 |=> int_mask_one_o[15:0] == $past(wd))
    else $error("mask lower half not loaded");
  AST_LONG_IND: assert property (wr_ok && sel == rmh_pkg::A_LAIH |=> long_individual_addr_o[47:32] == $past(wd))
    else $error("long individual msw wrong");
  AST_LONG_GRP: assert property (wr_ok && sel == rmh_pkg::A_LAGH |=> long_group_addr_o[47:32] == $past(wd))
    else $error("long group msw wrong");
  AST_MODE_BACK: assert property (take && rw && sel == rmh_pkg::A_MODE |-> ##2 host_data_bus_o == $past(mode_one_o, 2))
    else $error("mode one readback wrong");
  AST_STATE_READ: assert property (take && rw && sel == rmh_pkg::A_STM |-> ##2 host_data_bus_o == $past(protocol_state_i, 2) && host_data_bus_oe_o)
    else $error("protocol state readback wrong");
  AST_MAC_INFO: assert property (take && rw && sel == rmh_pkg::A_MIRL |-> ##2 host_data_bus_o == $past(mac_info_value_i[15:0], 2))
    else $error("mac info lower half wrong");
  AST_RO_WRITE: assert property (take_wr && sel >= rmh_pkg::A_STM |=> $stable(mode_one_o) && !command_one_stb_o && !access_refused_o)
    else $error("read-only write changed state");
  AST_WRITE_NO_DRIVE: assert property (take_wr |-> ##2 host_ack_o && !host_data_bus_oe_o)
    else $error("bus driven on write");
  AST_ACK_RELEASE: assert property (host_ack_o && !strb |=> !host_ack_o && !host_data_bus_oe_o)
    else $error("ack held after strobe release");

  COV_READ: cover property (take && rw ##2 host_data_bus_oe_o);
  COV_CMD: cover property (command_one_stb_o);
  COV_REFUSE: cover property (access_refused_o);
  COV_ASYNC: cover property (st_r == rmh_pkg::PS_IDLE && !smode_r ##1 take);

endmodule

// File: inc/rmh_pkg.sv
// ****************************************************************
// constants of the host register port
// ****************************************************************
package rmh_pkg;

  localparam int          ADDR_W     = 7;
  localparam int          DATA_W     = 16;
  localparam int          NUM_WORDS  = 13;
  localparam int          SYNC_W     = 26;

  // ****************************************************************
  // register select codes
  // ****************************************************************
  localparam logic [6:0]  A_CMD1     = 7'h00;
  localparam logic [6:0]  A_CMD2     = 7'h01;
  localparam logic [6:0]  A_STATUS_ONE_UPPER     = 7'h00;
  localparam logic [6:0]  A_STATUS_ONE_LOWER     = 7'h01;
  localparam logic [6:0]  A_STATUS_TWO_UPPER     = 7'h02;
  localparam logic [6:0]  A_STATUS_TWO_LOWER     = 7'h03;
  localparam logic [6:0]  A_MSK1U    = 7'h04;
  localparam logic [6:0]  A_SHORT_INDIVIDUAL_ADDR     = 7'h08;
  localparam logic [6:0]  A_LAIH     = 7'h09;
  localparam logic [6:0]  A_LAGH     = 7'h0D;
  localparam logic [6:0]  A_MODE     = 7'h10;
  localparam logic [6:0]  A_STM      = 7'h11;
  localparam logic [6:0]  A_MIRU     = 7'h12;
  localparam logic [6:0]  A_MIRL     = 7'h13;

  // ****************************************************************
  // word indices inside the register file
  // ****************************************************************
  localparam logic [3:0]  W_MSK1U    = 4'h0;
  localparam logic [3:0]  W_MSK1L    = 4'h1;
  localparam logic [3:0]  W_MSK2U    = 4'h2;
  localparam logic [3:0]  W_MSK2L    = 4'h3;
  localparam logic [3:0]  W_SHORT_INDIVIDUAL_ADDR     = 4'h4;
  localparam logic [3:0]  W_LAIH     = 4'h5;
  localparam logic [3:0]  W_LONG_INDIVIDUAL_ADDR_HIGH     = 4'h6;
  localparam logic [3:0]  W_LONG_INDIVIDUAL_ADDR_LOW     = 4'h7;
  localparam logic [3:0]  W_SHORT_GROUP_ADDR     = 4'h8;
  localparam logic [3:0]  W_LAGH     = 4'h9;
  localparam logic [3:0]  W_LONG_GROUP_ADDR_HIGH     = 4'hA;
  localparam logic [3:0]  W_LONG_GROUP_ADDR_LOW     = 4'hB;
  localparam logic [3:0]  W_MODE     = 4'hC;

  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [15:0] CMD_RST    = 16'h0000;
  localparam logic [1:0]  STRAP_WAIT = 2'h2;
  localparam logic        HOST_RD    = 1'b1;

  typedef enum {PS_STRAP, PS_IDLE, PS_STAGE, PS_HOLD} rmh_port_state_t;

  function automatic logic is_word(input logic [6:0] a);
    return (a >= A_MSK1U) && (a <= A_MODE);
  endfunction

  function automatic logic is_init_only(input logic [6:0] a);
    return (a >= A_SHORT_INDIVIDUAL_ADDR) && (a <= A_MODE);
  endfunction

  function automatic logic [3:0] word_idx(input logic [6:0] a);
    logic [6:0] d;
    d = a - A_MSK1U;
    return d[3:0];
  endfunction

endpackage

// File: hw/rmh_sync.sv
`timescale 1ns/10ps
// ****************************************************************
// two stage synchroniser for the host pins
// ****************************************************************
module rmh_sync (
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic [rmh_pkg::SYNC_W-1:0] async_i,
  output logic      [rmh_pkg::SYNC_W-1:0] sync_o
);

  logic [rmh_pkg::SYNC_W-1:0] meta_r;
  logic [rmh_pkg::SYNC_W-1:0] meta_nxt;
  logic [rmh_pkg::SYNC_W-1:0] sync_r;
  logic [rmh_pkg::SYNC_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule

// File: hw/rmh_regfile.sv
`timescale 1ns/10ps
// ****************************************************************
// read/write words: masks, addresses, mode
// ****************************************************************
module rmh_regfile (
  input  wire logic                                             core_clk_i,
  input  wire logic                                             nrst_i,
  input  wire logic                                             wr_en_i,
  input  wire logic [3:0]                                       wr_idx_i,
  input  wire logic [rmh_pkg::DATA_W-1:0]                       wr_data_i,
  input  wire logic [3:0]                                       rd_idx_i,
  output logic      [rmh_pkg::DATA_W-1:0]                       rd_data_o,
  output logic      [rmh_pkg::NUM_WORDS-1:0][rmh_pkg::DATA_W-1:0] words_o
);

  logic [rmh_pkg::NUM_WORDS-1:0][rmh_pkg::DATA_W-1:0] mem_r;
  logic [rmh_pkg::NUM_WORDS-1:0][rmh_pkg::DATA_W-1:0] mem_nxt;
  logic [rmh_pkg::DATA_W-1:0]                         rd_r;
  logic [rmh_pkg::DATA_W-1:0]                         rd_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (wr_en_i && (wr_idx_i < 4'(rmh_pkg::NUM_WORDS))) begin
      mem_nxt[wr_idx_i] = wr_data_i;
    end
    rd_nxt = rmh_pkg::WORD_RST;
    if (rd_idx_i < 4'(rmh_pkg::NUM_WORDS)) begin
      rd_nxt = mem_r[rd_idx_i];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mem_r <= {rmh_pkg::NUM_WORDS{rmh_pkg::WORD_RST}};
      rd_r  <= rmh_pkg::WORD_RST;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign rd_data_o = rd_r;
  assign words_o   = mem_r;

endmodule

// File: dv/rmh_host_model.sv
`timescale 1ns/10ps
// ****************************************************************
// node processor on the host register bus
// ****************************************************************
module rmh_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] dev_data_i,
  input  wire logic        dev_oe_i,
  input  wire logic        ack_i,
  output logic             access_o,
  output logic             rw_o,
  output logic      [6:0]  sel_o,
  output logic      [15:0] bus_o
);
  logic        drive_r;
  logic [15:0] wdata_r;
  int          waits;
  int          timeouts;
  logic        oe_seen;

  initial begin
    access_o = 1'b0;
    rw_o     = 1'b1;
    sel_o    = 7'h00;
    drive_r  = 1'b0;
    wdata_r  = 16'h0000;
    timeouts = 0;
    oe_seen  = 1'b0;
  end

  // released bus shows the inverse of the word given to the last access, read or write
  assign bus_o = dev_oe_i ? dev_data_i : (drive_r ? wdata_r : ~wdata_r);

  // one whole access: request held until ack, then strobe dropped until ack falls
  task automatic access(input logic rw, input logic [6:0] sel, input logic [15:0] wd, output logic [15:0] rd);
    waits = 0;
    @(posedge core_clk_i);
    access_o <= 1'b1;
    rw_o     <= rw;
    sel_o    <= sel;
    wdata_r  <= wd;
    drive_r  <= ~rw;
    @(posedge core_clk_i);
    while (ack_i !== 1'b1 && waits < 60) begin
      @(posedge core_clk_i);
      waits++;
    end
    if (waits >= 60) begin
      timeouts++;
    end
    rd = bus_o;
    oe_seen = dev_oe_i;
    access_o <= 1'b0;
    drive_r  <= 1'b0;
    while (ack_i === 1'b1 && waits < 120) begin
      @(posedge core_clk_i);
      waits++;
    end
  endtask
endmodule

// File: dv/rmh_host_port_test.sv
`timescale 1ns/10ps
module rmh_host_port_test;
  logic        core_clk, nrst, strap, init_mode;
  logic [31:0] st1, st2, mac_info_value;
  logic [15:0] pstate;
  logic        acc, rw, oe, ack, c1_stb, c2_stb, refused, sync_mode;
  logic [6:0]  sel;
  logic [15:0] bus, dev_d, c1, c2, short_individual_addr, short_group_addr, mode;
  logic [31:0] msk1, msk2;
  logic [47:0] long_individual_addr, long_group_addr;
  int          fails, cmp_count, cycles, n_c1, n_c2, n_ref;

  rmh_host_port i_rmh_host_port (
    .core_clk_i(core_clk), .nrst_i(nrst), .host_port_timing_strap_i(strap), .host_access_i(acc),
    .host_rw_i(rw), .host_reg_select_i(sel), .host_data_bus_i(bus), .host_data_bus_o(dev_d),
    .host_data_bus_oe_o(oe), .host_ack_o(ack), .init_mode_i(init_mode), .status_one_i(st1),
    .status_two_i(st2), .protocol_state_i(pstate), .mac_info_value_i(mac_info_value), .command_one_o(c1),
    .command_one_stb_o(c1_stb), .command_two_o(c2), .command_two_stb_o(c2_stb),
    .access_refused_o(refused), .host_sync_mode_o(sync_mode), .int_mask_one_o(msk1),
    .int_mask_two_o(msk2), .short_individual_addr_o(short_individual_addr), .long_individual_addr_o(long_individual_addr),
    .short_group_addr_o(short_group_addr), .long_group_addr_o(long_group_addr), .mode_one_o(mode));

  rmh_host_model i_rmh_host_model (
    .core_clk_i(core_clk), .dev_data_i(dev_d), .dev_oe_i(oe), .ack_i(ack),
    .access_o(acc), .rw_o(rw), .sel_o(sel), .bus_o(bus));

  // ****************************************************************
  // clock, pulse counters, hang guard
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    n_c1   <= n_c1 + int'(c1_stb === 1'b1);
    n_c2   <= n_c2 + int'(c2_stb === 1'b1);
    n_ref  <= n_ref + int'(refused === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] val(input logic [6:0] a);
    return {4'hC, 5'h00, a};
  endfunction

  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_rmh_host_model.access(rmh_pkg::HOST_RD, a, 16'h0000, d);
    chk($sformatf("read %h", a), 48'(d), 48'(e));
    chk("read drive", 48'(i_rmh_host_model.oe_seen), 48'h1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    logic [15:0] d;
    i_rmh_host_model.access(~rmh_pkg::HOST_RD, a, w, d);
    chk("write drive", 48'(i_rmh_host_model.oe_seen), 48'h0);
  endtask

  task automatic do_reset(input logic s);
    strap <= s;
    nrst  <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst  <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic test_done;
    chk("host timeouts", 48'(i_rmh_host_model.timeouts), 48'h0);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_vals;
    chk("sync mode", 48'(sync_mode), 48'h1);
    chk("mask one", 48'(msk1), 48'h0);
    for (int a = 4; a <= 16; a++) begin
      rd(7'(a), 16'h0000);
    end
  endtask

  task automatic t_cmd;
    wr(rmh_pkg::A_CMD1, 16'hA55A);
    wr(rmh_pkg::A_CMD2, 16'h0FF0);
    chk("cmd one", 48'(c1), 48'hA55A);
    chk("cmd two", 48'(c2), 48'h0FF0);
    chk("cmd one pulses", 48'(n_c1), 48'h1);
    chk("cmd two pulses", 48'(n_c2), 48'h1);
    rd(rmh_pkg::A_STATUS_ONE_UPPER, st1[31:16]);
  endtask

  task automatic t_status;
    rd(7'h00, st1[31:16]);
    rd(7'h01, st1[15:0]);
    rd(7'h02, st2[31:16]);
    rd(7'h03, st2[15:0]);
    rd(7'h11, pstate);
    rd(7'h12, mac_info_value[31:16]);
    rd(7'h13, mac_info_value[15:0]);
  endtask

  task automatic t_words;
    init_mode <= 1'b1;
    for (int a = 4; a <= 16; a++) begin
      wr(7'(a), val(7'(a)));
    end
    for (int a = 4; a <= 16; a++) begin
      rd(7'(a), val(7'(a)));
    end
    chk("mask one", 48'(msk1), 48'({val(7'h04), val(7'h05)}));
    chk("mask two", 48'(msk2), 48'({val(7'h06), val(7'h07)}));
    chk("short ind", 48'(short_individual_addr), 48'(val(7'h08)));
    chk("long ind", long_individual_addr, {val(7'h09), val(7'h0A), val(7'h0B)});
    chk("short grp", 48'(short_group_addr), 48'(val(7'h0C)));
    chk("long grp", long_group_addr, {val(7'h0D), val(7'h0E), val(7'h0F)});
    chk("mode one", 48'(mode), 48'(val(7'h10)));
  endtask

  task automatic t_refuse;
    init_mode <= 1'b0;
    wr(7'h08, 16'h1234);
    wr(7'h10, 16'h4321);
    wr(7'h05, 16'h5A5A);
    chk("refusals", 48'(n_ref), 48'h2);
    rd(7'h08, val(7'h08));
    chk("mode one", 48'(mode), 48'(val(7'h10)));
    chk("mask one", 48'(msk1), 48'({val(7'h04), 16'h5A5A}));
  endtask

  task automatic t_ignore;
    init_mode <= 1'b1;
    wr(7'h02, 16'hFFFF);
    wr(7'h11, 16'hFFFF);
    wr(7'h14, 16'hFFFF);
    wr(7'h7F, 16'hFFFF);
    rd(7'h14, 16'h0000);
    rd(7'h7F, 16'h0000);
    rd(7'h02, st2[31:16]);
    chk("cmd pulses", 48'(n_c1 + n_c2), 48'h2);
    chk("long grp", long_group_addr, {val(7'h0D), val(7'h0E), val(7'h0F)});
    chk("mask two", 48'(msk2), 48'({val(7'h06), val(7'h07)}));
    chk("mode one", 48'(mode), 48'(val(7'h10)));
  endtask

  task automatic t_async;
    do_reset(1'b0);
    chk("sync mode", 48'(sync_mode), 48'h0);
    rd(7'h0C, 16'h0000);
    wr(7'h0C, 16'h3C3C);
    rd(7'h0C, 16'h3C3C);
    chk("short grp", 48'(short_group_addr), 48'h3C3C);
    wr(7'h00, 16'h00C3);
    chk("cmd one", 48'(c1), 48'h00C3);
    rd(7'h13, mac_info_value[15:0]);
  endtask

  initial begin
    nrst      = 1'b0;
    strap     = 1'b1;
    init_mode = 1'b0;
    st1       = 32'h13579BDF;
    st2       = 32'h2468ACE0;
    mac_info_value       = 32'h84217BDE;
    pstate    = 16'h0F1E;
    fails     = 0;
    cmp_count = 0;
    cycles    = 0;
    n_c1      = 0;
    n_c2      = 0;
    n_ref     = 0;
    do_reset(1'b1);
    t_reset_vals();
    t_cmd();
    t_status();
    t_words();
    t_refuse();
    t_ignore();
    t_async();
    test_done();
  end
endmodule
